// [logic/tprf_pkg.sv]
// Purpose: shared constants and types for the three-port bit register file
// Assumes: one system clock; device pins sampled synchronously
// Notes: word count and select width fixed by the storage organisation
package tprf_pkg;
    localparam int WORDS = 8;
    localparam int SEL_W = 3;
    localparam logic [7:0] MASTER_RST = 8'h00;
    localparam logic SLAVE_RST = 1'h0;

    typedef logic [SEL_W-1:0] tprf_sel_t;

    typedef struct packed {
        tprf_sel_t write_select;
        tprf_sel_t first_read_select;
        tprf_sel_t second_read_select;
        logic write_bit_in;
    } tprf_req_t;

    typedef struct packed {
        logic first_read_out;
        logic second_read_out;
    } tprf_rsp_t;
endpackage

// [logic/tprf_regfile.sv]
// Purpose: eight word by one bit register file, one write and two read ports
// Assumes: clock_pulse_in is a plain input sampled on CLOCK
// Notes: pin edges found by comparing with the previous sample
//     a pin pulse shorter than one CLOCK period is not seen at all
//     reset to zero is a choice; the stored bits have no defined power-up value
//
// Functional notes
// - eight one-bit words; at most one write and two reads per cycle
// - falling clock_pulse_in writes write_bit_in into word at write_select
// - rising clock_pulse_in copies the two selected words into the slaves
// - slave_transparent_n low makes outputs follow selected words without edges
`timescale 1ns/10ps
module tprf_regfile
    import tprf_pkg::*;
#(
    parameter int N_WORDS = WORDS,
    parameter int N_SEL = SEL_W
)
(
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire tprf_pkg::tprf_req_t REQ,
    input wire logic CLOCK_PULSE_IN,
    input wire logic SLAVE_TRANSPARENT_N,
    output tprf_pkg::tprf_rsp_t RSP
);
    import tprf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // the request struct fixes both sizes, so other values cannot be served
    generate
        if (N_WORDS != WORDS || N_SEL != SEL_W || N_WORDS != (1 << N_SEL))
        begin : g_size_check
            $error("tprf_regfile: N_WORDS and N_SEL must match the request layout");
        end
    endgenerate

    logic [N_WORDS-1:0] master_r;
    logic [N_WORDS-1:0] master_nxt;
    logic cp_r;
    logic cp_nxt;
    tprf_rsp_t slave_r;
    tprf_rsp_t slave_nxt;
    logic cp_fall;
    logic cp_rise;

    // word lookup shared by both read ports
    function automatic logic pick(input logic [N_WORDS-1:0] m, input tprf_sel_t s);
        pick = m[s];
    endfunction

    // one-hot mask of a word, used by the checks to isolate untouched words
    function automatic logic [N_WORDS-1:0] word_mask(input tprf_sel_t s);
        word_mask = '0;
        word_mask[s] = 1'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // edge detection on the clock pulse pin
    // the pin is only sampled, so a pulse shorter than one CLOCK period is lost
    assign cp_fall = cp_r && !CLOCK_PULSE_IN;
    assign cp_rise = !cp_r && CLOCK_PULSE_IN;
    assign cp_nxt = CLOCK_PULSE_IN;

    ////////////////////////////////////////////////////////////////////////////
    // masters
    always_comb
    begin
        master_nxt = master_r;
        if (cp_fall)
        begin
            master_nxt[REQ.write_select] = REQ.write_bit_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // slaves; transparency uses the updated masters so a write shows at once
    always_comb
    begin
        slave_nxt = slave_r;
        if (!SLAVE_TRANSPARENT_N || cp_rise)
        begin
            slave_nxt.first_read_out = pick(master_nxt, REQ.first_read_select);
            slave_nxt.second_read_out = pick(master_nxt, REQ.second_read_select);
        end
    end

    // previous pin sample; zero after reset, so a high pin then reads as a rise
    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cp_r <= 1'h0;
        end
        else
        begin
            cp_r <= cp_nxt;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            master_r <= MASTER_RST;
        end
        else
        begin
            master_r <= master_nxt;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            slave_r <= {SLAVE_RST, SLAVE_RST};
        end
        else
        begin
            slave_r <= slave_nxt;
        end
    end

    assign RSP = slave_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_fall;
        cp_r && !CLOCK_PULSE_IN;
    endsequence

    sequence s_rise;
        !cp_r && CLOCK_PULSE_IN;
    endsequence

    property p_write;
        @(posedge CLOCK) disable iff (!RESET_N)
        s_fall |=> master_r[$past(REQ.write_select)] == $past(REQ.write_bit_in);
    endproperty
    a_write: assert property (p_write) else $error("write missed");

    property p_rise_first;
        @(posedge CLOCK) disable iff (!RESET_N)
        s_rise |=> RSP.first_read_out == master_r[$past(REQ.first_read_select)];
    endproperty
    a_rise_first: assert property (p_rise_first) else $error("first slave wrong");

    property p_rise_second;
        @(posedge CLOCK) disable iff (!RESET_N)
        s_rise |=> RSP.second_read_out == master_r[$past(REQ.second_read_select)];
    endproperty
    a_rise_second: assert property (p_rise_second) else $error("second slave wrong");

    property p_transparent;
        @(posedge CLOCK) disable iff (!RESET_N)
        !SLAVE_TRANSPARENT_N |=> RSP.first_read_out == master_r[$past(REQ.first_read_select)]
            && RSP.second_read_out == master_r[$past(REQ.second_read_select)];
    endproperty
    a_transparent: assert property (p_transparent) else $error("not transparent");

    property p_slave_hold;
        @(posedge CLOCK) disable iff (!RESET_N)
        (SLAVE_TRANSPARENT_N && !(!cp_r && CLOCK_PULSE_IN)) |=> $stable(RSP);
    endproperty
    a_slave_hold: assert property (p_slave_hold) else $error("slave drifted");

    property p_master_hold;
        @(posedge CLOCK) disable iff (!RESET_N)
        !(cp_r && !CLOCK_PULSE_IN) |=> $stable(master_r);
    endproperty
    a_master_hold: assert property (p_master_hold) else $error("master drifted");

    property p_single_word;
        @(posedge CLOCK) disable iff (!RESET_N)
        s_fall |=> $countones(master_r ^ $past(master_r)) <= 1;
    endproperty
    a_single_word: assert property (p_single_word) else $error("multi write");

    sequence s_write_read_first;
        s_fall ##1 (s_rise and (REQ.first_read_select == $past(REQ.write_select)));
    endsequence

    sequence s_write_read_second;
        s_fall ##1 (s_rise and (REQ.second_read_select == $past(REQ.write_select)));
    endsequence

    sequence s_see_first;
        s_fall and (!SLAVE_TRANSPARENT_N && REQ.first_read_select == REQ.write_select);
    endsequence

    sequence s_see_second;
        s_fall and (!SLAVE_TRANSPARENT_N && REQ.second_read_select == REQ.write_select);
    endsequence

    property p_write_then_read;
        @(posedge CLOCK) disable iff (!RESET_N)
        s_write_read_first |=> RSP.first_read_out == $past(REQ.write_bit_in, 2);
    endproperty
    a_write_then_read: assert property (p_write_then_read) else $error("readback bad");

    property p_wr_rd_second;
        @(posedge CLOCK) disable iff (!RESET_N)
        s_write_read_second |=> RSP.second_read_out == $past(REQ.write_bit_in, 2);
    endproperty
    a_wr_rd_second: assert property (p_wr_rd_second) else $error("readback bad");

    property p_other_words;
        @(posedge CLOCK) disable iff (!RESET_N)
        s_fall |=> ((master_r ^ $past(master_r)) & ~word_mask($past(REQ.write_select))) == '0;
    endproperty
    a_other_words: assert property (p_other_words) else $error("stray write");

    property p_see_first;
        @(posedge CLOCK) disable iff (!RESET_N)
        s_see_first |=> RSP.first_read_out == $past(REQ.write_bit_in);
    endproperty
    a_see_first: assert property (p_see_first) else $error("write not seen");

    property p_see_second;
        @(posedge CLOCK) disable iff (!RESET_N)
        s_see_second |=> RSP.second_read_out == $past(REQ.write_bit_in);
    endproperty
    a_see_second: assert property (p_see_second) else $error("write not seen");
endmodule

// [sim/tprf_datapath.sv]
// Purpose: datapath model driving selects, write data and device clock pin
// Assumes: fixed seed so every run repeats
// Notes: toggle forces a pin change every cycle
`timescale 1ns/10ps
module tprf_datapath
    import tprf_pkg::*;
(
    input wire logic clk,
    input wire logic toggle,
    input wire logic same,
    output tprf_pkg::tprf_req_t req,
    output logic pin
);
    integer seed = 61122;
    tprf_req_t nxt;
    initial
    begin
        req = '0;
        pin = 1'b0;
    end
    ////////////////////////////////////////
    always @(posedge clk)
    begin
        nxt = 10'($random(seed));
        if (same)
        begin
            // corner: the write and both reads hammer the top word
            nxt.write_select = 3'h7;
            nxt.first_read_select = 3'h7;
            nxt.second_read_select = 3'h7;
        end
        req <= nxt;
        pin <= toggle ? ~pin : 1'($random(seed));
    end
endmodule

// [sim/tb_top.sv]
// Purpose: random self-checking bench for the register file
// Assumes: outputs settle by the falling CLOCK edge
// Notes: reference writes before loading, as the design does
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s expected %b seen %b", n, e, g); end end
module tb_top;
    import tprf_pkg::*;
    logic CLOCK = 1'b0;
    logic RESET_N = 1'b0;
    logic slv_n = 1'b1;
    logic toggle = 1'b0;
    logic same = 1'h0;
    logic live = 1'b0;
    logic pin;
    tprf_req_t req;
    tprf_rsp_t rsp;
    logic [7:0] mem;
    logic prev;
    logic [1:0] exp_out;
    int miscompares = 0;
    int checked = 0;
    always #4 CLOCK = ~CLOCK;
    tprf_datapath i_tprf_datapath (.clk(CLOCK), .toggle(toggle), .same(same), .req(req),
        .pin(pin));
    function automatic logic [1:0] reads(input logic [7:0] m, input tprf_req_t r);
        reads = {m[r.first_read_select], m[r.second_read_select]};
    endfunction
    tprf_regfile i_tprf_regfile (.CLOCK(CLOCK), .RESET_N(RESET_N), .REQ(req),
        .CLOCK_PULSE_IN(pin), .SLAVE_TRANSPARENT_N(slv_n), .RSP(rsp));
    ////////////////////////////////////////
    always @(posedge CLOCK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            mem = MASTER_RST;
            prev = 1'b0;
            exp_out = {2{SLAVE_RST}};
        end
        else
        begin
            if (prev && !pin)
                mem[req.write_select] = req.write_bit_in;
            if ((!prev && pin) || !slv_n)
                exp_out = reads(mem, req);
            prev = pin;
        end
    end
    always @(negedge CLOCK)
    begin
        if (live)
        begin
            `CHK("first_read_out", exp_out[1], rsp.first_read_out)
            `CHK("second_read_out", exp_out[0], rsp.second_read_out)
        end
    end
    ////////////////////////////////////////
    task automatic final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge CLOCK);
        RESET_N <= 1'b1;
        live <= 1'b1;
        repeat (1000) @(posedge CLOCK);
        slv_n <= 1'b0;
        repeat (500) @(posedge CLOCK);
        slv_n <= 1'b1;
        toggle <= 1'b1;
        repeat (250) @(posedge CLOCK);
        same <= 1'h1;
        repeat (250) @(posedge CLOCK);
        RESET_N <= 1'b0;
        toggle <= 1'b0;
        same <= 1'h0;
        repeat (2) @(posedge CLOCK);
        RESET_N <= 1'b1;
        repeat (500) @(posedge CLOCK);
        final_report();
    end
    initial
    begin
        repeat (4000) @(posedge CLOCK);
        miscompares++;
        final_report();
    end
endmodule
